// File: cpt_port.sv
// Codec serial port: framed slot link for I2S and AC-link with byte reversal.
// Assumes synchronous pins, a playback source that answers in the request cycle,
// and a record sink that always accepts.
//
// Operation
// - I2S frames hold two slots, left sample then right sample.
// - I2S carries only audio, no command or status slots.
// - I2S frame sync is low throughout the left slot.
// - I2S sync and data change on falling clock, input sampled rising.
// - Data delay one starts data one bit clock after sync edge.
// - I2S slots are programmable, default 32 clocks, unused bits zero.
// - I2S bit clock is master serial clock divided by four, 64 per frame.
// - Byte reversal applies to playback and record streams together.
// - Byte reversal turns words big-endian using slot length and bits per slot.
// - Nibble short samples also swap nibbles of the most significant byte.
// - AC-link frames are full duplex with thirteen slots.
// - AC-link slot 0 lasts 16 clocks, others 20, frame 256.
// - Generated codec master clock runs at 24.576 MHz.
// - AC-link sync is high during slot 0; frame starts at its rise.
// - Slots 1 and 2 carry command out and status in.
// - Unused slots and unused bits transmit as zero.
// - AC-link 2.0 record input is primary ORed with secondary input.
// - Active-low request flags in slot 1 bits 2-11 gate next frame.
// - On-demand sampling only with a single codec.
// - Output slots follow programmed tags, input slots follow received tag.
`timescale 1ns/1ps
module cpt_port (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	output logic playReq,
	output logic [3:0] playSlot,
	input wire logic [31:0] playData,
	output logic recValid,
	output logic [3:0] recSlot,
	output logic [31:0] recData,
	output logic frameSyncPin,
	output logic serialBitClockPinOut,
	output logic serialBitClockPinOe,
	input wire logic serialBitClockPinIn,
	output logic serialDataOutPin,
	input wire logic serialDataInPin,
	input wire logic secondaryChannelInput,
	output logic codecResetOutn,
	output logic masterClockOut
);

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	// ********************************
	// Byte reversal
	// ********************************
	function automatic logic [31:0] cpt_bswap(input logic [31:0] w, input logic [5:0] bps, input logic [5:0] len);
		logic [31:0] r;
		logic [2:0] nb;
		r = '0;
		nb = 3'((bps + 6'h07) >> 3);
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < nb) begin
				r[8 * (int'(nb) - 1 - i) +: 8] = w[8 * i +: 8];
			end
		end
		if (len - bps == 6'h04) begin
			r[7:0] = {r[3:0], r[7:4]};
		end
		return r;
	endfunction

	// ********************************
	// Registers
	// ********************************
	logic [7:0] ctrl_ff;
	logic [5:0] bps_ff;
	logic [5:0] len_ff;
	logic [5:0] first_ff;
	logic [11:0] tags_ff;
	logic [19:0] cmdAddr_ff;
	logic [19:0] cmdData_ff;
	logic [19:0] stsAddr_ff;
	logic [19:0] stsData_ff;
	logic [15:0] rxTag_ff;
	logic [9:0] req_ff;
	logic [9:0] reqLatch_ff;
	logic cmdPend_ff;
	logic cmdSend_ff;
	logic [31:0] regRdData_ff;
	logic [31:0] rdMux;
	logic cmdDone;
	cpt_pkg::cpt_mode_t mode;
	logic isI2s;
	logic isAc;
	logic isAc2;
	logic swapEn;
	logic odOn;

	assign mode = cpt_pkg::cpt_mode_t'(ctrl_ff[cpt_pkg::CTRL_MODE +: 2]);
	assign isI2s = (mode == cpt_pkg::CPT_I2S);
	assign isAc = (mode == cpt_pkg::CPT_AC1) || (mode == cpt_pkg::CPT_AC2);
	assign isAc2 = (mode == cpt_pkg::CPT_AC2);
	assign swapEn = ctrl_ff[cpt_pkg::CTRL_SWAP];
	// Two codecs could both answer a request, so on-demand is single codec only
	assign odOn = isAc2 && ctrl_ff[cpt_pkg::CTRL_ODS] && !ctrl_ff[cpt_pkg::CTRL_DUAL];
	assign codecResetOutn = ctrl_ff[cpt_pkg::CTRL_CRST];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= cpt_pkg::CTRL_RST;
			bps_ff <= cpt_pkg::BPS_RST;
			len_ff <= cpt_pkg::LEN_RST;
			first_ff <= cpt_pkg::FIRST_RST;
			tags_ff <= '0;
			cmdAddr_ff <= '0;
			cmdData_ff <= '0;
		end else if (regWrite) begin
			unique case (regAddr)
				cpt_pkg::ADDR_CTRL: ctrl_ff <= regWrData[7:0];
				cpt_pkg::ADDR_SLOTCFG: begin
					bps_ff <= regWrData[cpt_pkg::CFG_BPS +: 6];
					len_ff <= regWrData[cpt_pkg::CFG_LEN +: 6];
					first_ff <= regWrData[cpt_pkg::CFG_FIRST +: 6];
				end
				cpt_pkg::ADDR_TAGS: tags_ff <= regWrData[11:0];
				cpt_pkg::ADDR_CMDADDR: cmdAddr_ff <= regWrData[19:0];
				cpt_pkg::ADDR_CMDDATA: cmdData_ff <= regWrData[19:0];
				default: ;
			endcase
		end
	end

	// A write in the cycle the command leaves still queues a new one
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmdPend_ff <= 1'b0;
		end else if (regWrite && regAddr == cpt_pkg::ADDR_CMDDATA) begin
			cmdPend_ff <= 1'b1;
		end else if (cmdDone) begin
			cmdPend_ff <= 1'b0;
		end
	end

	always_comb begin
		rdMux = '0;
		unique case (regAddr)
			cpt_pkg::ADDR_CTRL: rdMux[7:0] = ctrl_ff;
			cpt_pkg::ADDR_SLOTCFG: begin
				rdMux[cpt_pkg::CFG_BPS +: 6] = bps_ff;
				rdMux[cpt_pkg::CFG_LEN +: 6] = len_ff;
				rdMux[cpt_pkg::CFG_FIRST +: 6] = first_ff;
			end
			cpt_pkg::ADDR_TAGS: rdMux[11:0] = tags_ff;
			cpt_pkg::ADDR_CMDADDR: rdMux[19:0] = cmdAddr_ff;
			cpt_pkg::ADDR_CMDDATA: rdMux[19:0] = cmdData_ff;
			cpt_pkg::ADDR_STATUS: begin
				rdMux[15:0] = rxTag_ff;
				rdMux[cpt_pkg::STAT_PEND] = cmdPend_ff;
				rdMux[cpt_pkg::STAT_REQ +: 10] = req_ff;
			end
			cpt_pkg::ADDR_STSADDR: rdMux[19:0] = stsAddr_ff;
			cpt_pkg::ADDR_STSDATA: rdMux[19:0] = stsData_ff;
			default: rdMux = '0;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			regRdData_ff <= '0;
		end else begin
			regRdData_ff <= regRead ? rdMux : '0;
		end
	end
	assign regRdData = regRdData_ff;

	// ********************************
	// Clocks
	// ********************************
	logic [1:0] divCnt_ff;
	logic bitClkGen_ff;
	logic sclkPrev_ff;
	logic [15:0] mclkAcc_ff;
	logic sclk;
	logic launch;
	logic capture;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			divCnt_ff <= '0;
			bitClkGen_ff <= 1'b0;
		end else if (divCnt_ff == cpt_pkg::DIV_HALF_LAST) begin
			divCnt_ff <= '0;
			bitClkGen_ff <= !bitClkGen_ff;
		end else begin
			divCnt_ff <= divCnt_ff + 2'h1;
		end
	end

	// Phase accumulator: truncated increment gives an average rate of about 24575.8 kHz, edges jitter by one system clock
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mclkAcc_ff <= '0;
		end else if (ctrl_ff[cpt_pkg::CTRL_MCLK]) begin
			mclkAcc_ff <= mclkAcc_ff + cpt_pkg::MCLK_INC;
		end else begin
			mclkAcc_ff <= '0;
		end
	end
	assign masterClockOut = mclkAcc_ff[15];

	assign sclk = isI2s ? bitClkGen_ff : serialBitClockPinIn;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sclkPrev_ff <= 1'b0;
		end else begin
			sclkPrev_ff <= sclk;
		end
	end
	assign launch = isI2s ? (sclkPrev_ff && !sclk) : (isAc && !sclkPrev_ff && sclk);
	assign capture = isI2s ? (!sclkPrev_ff && sclk) : (isAc && sclkPrev_ff && !sclk);
	assign serialBitClockPinOut = bitClkGen_ff;
	assign serialBitClockPinOe = isI2s;

	// ********************************
	// Frame and slot position
	// ********************************
	logic [7:0] fpos_ff;
	logic [3:0] dSlot_ff;
	logic [5:0] dBit_ff;
	logic dActive_ff;
	logic [7:0] nxtFpos;
	logic [3:0] nxtSlot;
	logic [5:0] nxtBit;
	logic nxtActive;
	logic [5:0] firstLen;
	logic [5:0] slotLen;
	logic [5:0] curLen;
	logic [3:0] nSlots;
	logic [7:0] frameLast;
	logic endSlot;
	logic slotStart;

	assign firstLen = isAc ? cpt_pkg::AC_FIRST_LEN : first_ff;
	assign slotLen = isAc ? cpt_pkg::AC_SLOT_LEN : len_ff;
	assign nSlots = isAc ? cpt_pkg::AC_SLOTS : cpt_pkg::I2S_SLOTS;
	assign curLen = (dSlot_ff == 4'h0) ? firstLen : slotLen;
	assign frameLast = isAc ? cpt_pkg::AC_FRAME_LAST : 8'({2'h0, first_ff} + {2'h0, len_ff} - 8'h01);
	assign endSlot = dBit_ff == curLen - 6'h01;
	assign nxtFpos = (fpos_ff == frameLast) ? 8'h00 : fpos_ff + 8'h01;

	always_comb begin
		nxtSlot = dSlot_ff;
		nxtBit = dBit_ff;
		nxtActive = dActive_ff;
		if (nxtFpos == {7'h00, ctrl_ff[cpt_pkg::CTRL_DELAY]}) begin
			nxtSlot = 4'h0;
			nxtBit = 6'h00;
			nxtActive = 1'b1;
		end else if (dActive_ff && endSlot) begin
			nxtBit = 6'h00;
			if (dSlot_ff == nSlots - 4'h1) begin
				nxtSlot = 4'h0;
				nxtActive = 1'b0;
			end else begin
				nxtSlot = dSlot_ff + 4'h1;
			end
		end else if (dActive_ff) begin
			nxtBit = dBit_ff + 6'h01;
		end
	end
	assign slotStart = nxtActive && nxtBit == 6'h00;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fpos_ff <= cpt_pkg::AC_FRAME_LAST;
			dSlot_ff <= '0;
			dBit_ff <= '0;
			dActive_ff <= 1'b0;
		end else if (!isI2s && !isAc) begin
			// Idle parks the frame, so every entry from idle starts with a clean frame
			fpos_ff <= cpt_pkg::AC_FRAME_LAST;
			dSlot_ff <= '0;
			dBit_ff <= '0;
			dActive_ff <= 1'b0;
		end else if (launch) begin
			fpos_ff <= nxtFpos;
			dSlot_ff <= nxtSlot;
			dBit_ff <= nxtBit;
			dActive_ff <= nxtActive;
		end
	end

	// ********************************
	// Transmit
	// ********************************
	logic [12:1] txValid;
	logic [15:0] tagWord;
	logic [31:0] txSample;
	logic [31:0] txWord;
	logic [31:0] txShift_ff;
	logic frameSync_ff;
	logic dataOut_ff;
	logic syncNext;
	logic [5:0] txJust;

	always_comb begin
		txValid = '0;
		tagWord = '0;
		for (int s = 1; s <= 12; s++) begin
			if (s < 3) begin
				txValid[s] = cmdPend_ff;
			end else begin
				txValid[s] = tags_ff[s - 1] && !(odOn && reqLatch_ff[12 - s]);
			end
			tagWord[15 - s] = txValid[s];
		end
		tagWord[cpt_pkg::TAG_VALID] = |txValid;
	end

	// Mask then left-justify, so every bit past the sample shifts out as zero
	// Reversed words fill whole bytes, so they are justified by bytes, not by sample bits
	always_comb begin
		txJust = swapEn ? (6'h20 - ((bps_ff + 6'h07) & 6'h38)) : (6'h20 - bps_ff);
		txSample = playData & (32'hffffffff >> (6'h20 - bps_ff));
		if (swapEn) begin
			txSample = cpt_bswap(txSample, bps_ff, slotLen);
		end
		txWord = '0;
		if (isI2s) begin
			txWord = txSample << txJust;
		end else if (nxtSlot == 4'h0) begin
			txWord = {tagWord, 16'h0000};
		end else if (nxtSlot == 4'h1) begin
			txWord = cmdSend_ff ? {cmdAddr_ff, 12'h000} : '0;
		end else if (nxtSlot == 4'h2) begin
			txWord = cmdSend_ff ? {cmdData_ff, 12'h000} : '0;
		end else if (txValid[nxtSlot]) begin
			txWord = txSample << txJust;
		end
	end

	// Audio only in I2S, and slots 1-2 in AC-link are command, not audio
	assign playReq = launch && slotStart && (isI2s || (isAc && nxtSlot >= cpt_pkg::AUDIO_SLOT
		&& txValid[nxtSlot]));
	assign playSlot = nxtSlot;
	assign cmdDone = launch && slotStart && isAc && nxtSlot == 4'h2 && cmdSend_ff;
	assign syncNext = isAc ? (nxtFpos < {2'h0, cpt_pkg::AC_FIRST_LEN}) : !(nxtFpos < {2'h0, first_ff});

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmdSend_ff <= 1'b0;
		end else if (launch && slotStart && nxtSlot == 4'h0) begin
			cmdSend_ff <= isAc && cmdPend_ff;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			frameSync_ff <= 1'b0;
			dataOut_ff <= 1'b0;
			txShift_ff <= '0;
		end else if (!isI2s && !isAc) begin
			frameSync_ff <= 1'b0;
			dataOut_ff <= 1'b0;
		end else if (launch) begin
			frameSync_ff <= syncNext;
			if (slotStart) begin
				dataOut_ff <= txWord[31];
				txShift_ff <= {txWord[30:0], 1'b0};
			end else begin
				dataOut_ff <= nxtActive && txShift_ff[31];
				txShift_ff <= {txShift_ff[30:0], 1'b0};
			end
		end
	end
	assign frameSyncPin = frameSync_ff;
	assign serialDataOutPin = dataOut_ff;

	// ********************************
	// Receive
	// ********************************
	logic rxBit;
	logic [31:0] rxAcc_ff;
	logic [31:0] rxFull;
	logic [31:0] rxRj;
	logic rxAudioOk;
	logic recValid_ff;
	logic [3:0] recSlot_ff;
	logic [31:0] recData_ff;

	// Relies on an absent second codec holding its input low
	assign rxBit = serialDataInPin | (isAc2 & secondaryChannelInput);
	assign rxFull = {rxAcc_ff[30:0], rxBit};
	assign rxRj = (rxFull >> (curLen - bps_ff)) & (32'hffffffff >> (6'h20 - bps_ff));
	assign rxAudioOk = isI2s || (isAc && dSlot_ff >= cpt_pkg::AUDIO_SLOT
		&& rxTag_ff[4'hf - dSlot_ff]);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rxAcc_ff <= '0;
			recValid_ff <= 1'b0;
			recSlot_ff <= '0;
			recData_ff <= '0;
		end else begin
			recValid_ff <= 1'b0;
			if (capture && dActive_ff) begin
				rxAcc_ff <= rxFull;
				if (endSlot && rxAudioOk) begin
					recValid_ff <= 1'b1;
					recSlot_ff <= dSlot_ff;
					recData_ff <= swapEn ? cpt_bswap(rxRj, bps_ff, slotLen) : rxRj;
				end
			end
		end
	end
	assign recValid = recValid_ff;
	assign recSlot = recSlot_ff;
	assign recData = recData_ff;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rxTag_ff <= '0;
			stsAddr_ff <= '0;
			stsData_ff <= '0;
			req_ff <= '1;
		end else if (capture && dActive_ff && endSlot && isAc) begin
			unique case (dSlot_ff)
				4'h0: rxTag_ff <= rxFull[15:0];
				4'h1: begin
					stsAddr_ff <= rxFull[19:0];
					req_ff <= rxFull[cpt_pkg::REQ_HI:cpt_pkg::REQ_LO];
				end
				4'h2: stsData_ff <= rxFull[19:0];
				default: ;
			endcase
		end
	end

	// Requests seen in one frame steer the next; with delay zero its slot 0 tags still follow the older latch
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reqLatch_ff <= '1;
		end else if (launch && nxtFpos == 8'h00) begin
			reqLatch_ff <= req_ff;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	a_i2s_sync_low: assert property (isI2s && $fell(frameSync_ff) |-> fpos_ff == 8'h00)
		else $error("I2S sync fell away from frame start");
	a_i2s_sync_len: assert property (isI2s && $rose(frameSync_ff) |-> fpos_ff == {2'h0, first_ff})
		else $error("I2S sync low for wrong length");
	a_ac_sync_len: assert property (isAc && $fell(frameSync_ff) |-> fpos_ff == 8'h10)
		else $error("AC sync not high for slot 0");
	a_ac_frame_wrap: assert property (isAc && $changed(fpos_ff) && fpos_ff == 8'h00
		|-> $past(fpos_ff) == 8'hff)
		else $error("AC frame not 256 clocks");
	a_launch_edge: assert property ($changed(dataOut_ff) && $past(isI2s || isAc) |-> $past(launch))
		else $error("Data out moved off launch edge");
	a_i2s_slots: assert property (isI2s && playReq |-> playSlot < cpt_pkg::I2S_SLOTS)
		else $error("I2S played a third slot");
	a_i2s_no_status: assert property (isI2s |=> $stable(stsAddr_ff) && $stable(stsData_ff))
		else $error("Status captured in I2S");
	a_delay_start: assert property ((isI2s || isAc) && $changed(fpos_ff)
		&& fpos_ff == {7'h00, ctrl_ff[cpt_pkg::CTRL_DELAY]} |-> dSlot_ff == 4'h0 && dBit_ff == 6'h00)
		else $error("Data not aligned to delay");
	a_pad_zero: assert property (isAc && dActive_ff && dSlot_ff >= cpt_pkg::AUDIO_SLOT
		&& dBit_ff >= bps_ff && $changed(dBit_ff) |-> !dataOut_ff)
		else $error("Unused bit not zero");
	a_rec_tag: assert property (isAc && recValid_ff |-> rxTag_ff[4'hf - recSlot_ff])
		else $error("Record slot not tagged valid");

	c_i2s_frame: cover property (isI2s && launch && nxtFpos == 8'h00);
	c_ac_frame: cover property (isAc && launch && nxtFpos == 8'h00);
	c_record: cover property (recValid_ff && isAc2);
	c_command: cover property (cmdDone);

endmodule // cpt_port

// File: cpt_pkg.sv
// Constants of the codec serial port: register map, fields, resets, link timing.
// Assumes a 50 MHz system clock that also serves as the master serial clock.
package cpt_pkg;

	// ********************************
	// Register map and fields
	// ********************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SLOTCFG = 8'h04;
	localparam logic [7:0] ADDR_TAGS = 8'h08;
	localparam logic [7:0] ADDR_CMDADDR = 8'h0c;
	localparam logic [7:0] ADDR_CMDDATA = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_STSADDR = 8'h18;
	localparam logic [7:0] ADDR_STSDATA = 8'h1c;
	localparam int CTRL_MODE = 0;
	localparam int CTRL_DELAY = 2;
	localparam int CTRL_SWAP = 3;
	localparam int CTRL_ODS = 4;
	localparam int CTRL_DUAL = 5;
	localparam int CTRL_CRST = 6;
	localparam int CTRL_MCLK = 7;
	localparam int CFG_BPS = 0;
	localparam int CFG_LEN = 8;
	localparam int CFG_FIRST = 16;
	localparam int STAT_PEND = 16;
	localparam int STAT_REQ = 17;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [5:0] BPS_RST = 6'h18;
	localparam logic [5:0] LEN_RST = 6'h20;
	localparam logic [5:0] FIRST_RST = 6'h20;

	// ********************************
	// Link framing and clocks
	// ********************************
	localparam logic [5:0] AC_FIRST_LEN = 6'h10;
	localparam logic [5:0] AC_SLOT_LEN = 6'h14;
	localparam logic [3:0] AC_SLOTS = 4'hd;
	localparam logic [3:0] I2S_SLOTS = 4'h2;
	localparam logic [3:0] AUDIO_SLOT = 4'h3;
	localparam logic [7:0] AC_FRAME_LAST = 8'hff;
	localparam int TAG_VALID = 15;
	localparam int REQ_LO = 2;
	localparam int REQ_HI = 11;
	localparam int MASTER_SERIAL_CLOCK_DIV = 4;
	localparam logic [1:0] DIV_HALF_LAST = 2'(MASTER_SERIAL_CLOCK_DIV / 2 - 1);
	localparam int CLK_KHZ = 50000;
	localparam int MCLK_KHZ = 24576;
	localparam int BITCLK_KHZ = 12288;
	localparam logic [15:0] MCLK_INC = 16'(MCLK_KHZ * 65536 / CLK_KHZ);

	typedef enum logic [1:0] {CPT_IDLE, CPT_I2S, CPT_AC1, CPT_AC2} cpt_mode_t;

endpackage

// File: cpt_codec_model.sv
// Behavioural codec on the far side of the codec port: link clock, frame capture, record bits.
// Assumes the bench fills inBits/in2Bits and reads outBits/outSync just after a frame start.
`timescale 1ns/1ps
module cpt_codec_model #(
	parameter int HALF_BIT = 4
) (
	input wire logic clock,
	input wire logic acMode,
	input wire logic bitClkPin,
	input wire logic frameSyncPin,
	input wire logic serialDataOutPin,
	output logic acBitClk,
	output logic serialDataInPin,
	output logic secondaryChannelInput
);
	// ********************************
	// Link clock and frame tracking
	// ********************************
	logic inBits [256];
	logic in2Bits [256];
	logic outBits [256];
	logic outSync [256];
	logic bclkPrev = 1'b0;
	logic syncLast = 1'b0;
	int cnt = 0;
	int frameCount = 0;
	int frameCycles = 0;
	int cycles = 0;

	initial begin
		acBitClk = 1'b0;
		serialDataInPin = 1'b0;
		secondaryChannelInput = 1'b0;
		for (int i = 0; i < 256; i++) begin
			inBits[i] = 1'b0;
			in2Bits[i] = 1'b0;
		end
		// Scaled-down rate, so the port sees several system cycles per half bit
		forever begin
			repeat (HALF_BIT) @(posedge clock);
			acBitClk <= ~acBitClk;
		end
	end

	// Outgoing bit taken at the next launch edge, late in the bit, so output latency is tolerated
	always @(negedge clock) begin
		cycles++;
		if (acMode ? (bitClkPin && !bclkPrev) : (!bitClkPin && bclkPrev)) begin
			if (frameSyncPin == acMode && syncLast != acMode) begin
				cnt = 0;
				frameCount++;
				frameCycles = cycles;
				cycles = 0;
			end else begin
				cnt++;
			end
			syncLast = frameSyncPin;
			outBits[8'(cnt)] = serialDataOutPin;
			outSync[8'(cnt)] = frameSyncPin;
			serialDataInPin <= inBits[8'(cnt + 1)];
			secondaryChannelInput <= in2Bits[8'(cnt + 1)];
		end
		bclkPrev = bitClkPin;
	end
endmodule // cpt_codec_model

// File: codec_port_tdm_serial_bench.sv
// Self-checking bench of the codec port: register tasks, I2S and AC-link scenarios.
// Assumes cpt_pkg, cpt_port and the behavioural codec model are compiled first.
`timescale 1ns/1ps
module codec_port_tdm_serial_bench;
	// ********************************
	// Signals and helpers
	// ********************************
	localparam int BIT_HALF = 4;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdData;
	logic playReq;
	logic [3:0] playSlot;
	logic [31:0] playData;
	logic recValid;
	logic [3:0] recSlot;
	logic [31:0] recData;
	logic frameSyncPin, serialBitClockPinOut, serialBitClockPinOe, serialBitClockPinIn;
	logic serialDataOutPin, serialDataInPin, secondaryChannelInput, codecResetOutn, masterClockOut;
	logic acMode = 1'b0;
	logic acBitClk;
	logic cmdSeen;
	logic mclkPrev = 1'b0;
	logic [31:0] playTab [16];
	logic [31:0] recWords [16];
	int recHits [16];
	int playHits [16];
	int errCount = 0;
	int checkCount = 0;
	int cmdHits = 0;
	int mclkRises = 0;

	assign serialBitClockPinIn = serialBitClockPinOe ? serialBitClockPinOut : acBitClk;
	assign playData = playTab[playSlot];

	cpt_port dut_u (.clock, .resetn, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
		.playReq, .playSlot, .playData, .recValid, .recSlot, .recData, .frameSyncPin,
		.serialBitClockPinOut, .serialBitClockPinOe, .serialBitClockPinIn, .serialDataOutPin,
		.serialDataInPin, .secondaryChannelInput, .codecResetOutn, .masterClockOut);

	cpt_codec_model #(.HALF_BIT(BIT_HALF)) codec_u (.clock, .acMode, .bitClkPin(serialBitClockPinIn),
		.frameSyncPin, .serialDataOutPin, .acBitClk, .serialDataInPin, .secondaryChannelInput);

	initial begin
		forever begin
			#10 clock = ~clock;
		end
	end

	// Counted on the falling edge so that combinational pulses have settled
	always @(negedge clock) begin
		if (recValid === 1'b1) begin
			recWords[recSlot] = recData;
			recHits[recSlot]++;
		end
		if (playReq === 1'b1) begin
			playHits[playSlot]++;
		end
		mclkRises += int'(masterClockOut === 1'b1 && mclkPrev === 1'b0);
		mclkPrev = masterClockOut;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errCount++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	task automatic regRd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		check(regRdData, exp);
	endtask

	task automatic putIn(input bit sec, input int start, input int n, input logic [31:0] v);
		for (int i = 0; i < n; i++) begin
			if (sec) begin
				codec_u.in2Bits[start + i] = v[n - 1 - i];
			end else begin
				codec_u.inBits[start + i] = v[n - 1 - i];
			end
		end
	endtask

	function automatic logic [31:0] outWord(input bit sync, input int start, input int n);
		logic [31:0] w;
		w = 32'h0;
		for (int i = 0; i < n; i++) begin
			w = {w[30:0], sync ? codec_u.outSync[start + i] : codec_u.outBits[start + i]};
		end
		return w;
	endfunction

	task automatic waitFrames(input int n);
		int target;
		target = codec_u.frameCount + n;
		for (int i = 0; i < 20000 && codec_u.frameCount < target; i++) begin
			@(posedge clock);
		end
		check(32'(codec_u.frameCount >= target), 32'h1);
	endtask

	task automatic printVerdict();
		$display("checks %0d mismatches %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clock);
		errCount++;
		printVerdict();
	end

	// ********************************
	// Scenarios
	// ********************************
	initial begin
		playTab = '{default: 32'h0};
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		check(32'(codecResetOutn), 32'h0);
		regRd(cpt_pkg::ADDR_CTRL, 32'h0);
		regRd(cpt_pkg::ADDR_SLOTCFG, 32'h00202018);
		regRd(8'h20, 32'h0);
		// I2S, 24 of 32 bits, delay one
		playTab[0] = 32'hffabcdef;
		playTab[1] = 32'h00123456;
		putIn(0, 1, 24, 32'h00c0ffee);
		putIn(0, 33, 24, 32'h005a5a5a);
		regWr(cpt_pkg::ADDR_CTRL, 32'h5);
		waitFrames(3);
		check(32'(serialBitClockPinOe), 32'h1);
		check(32'(codec_u.frameCycles), 32'd256);
		check(outWord(0, 1, 32), 32'habcdef00);
		check(outWord(0, 33, 31), 32'h12345600 >> 1);
		check(outWord(1, 0, 32), 32'h0);
		check(outWord(1, 32, 32), 32'hffffffff);
		check(recWords[0], 32'h00c0ffee);
		check(recWords[1], 32'h005a5a5a);
		// Byte reversal with a nibble-short sample; idle first so the frame restarts cleanly
		regWr(cpt_pkg::ADDR_CTRL, 32'h0);
		regWr(cpt_pkg::ADDR_SLOTCFG, 32'h00181814);
		regWr(cpt_pkg::ADDR_CTRL, 32'hd);
		playTab[0] = 32'h00012345;
		putIn(0, 1, 24, 32'h00abcde0);
		waitFrames(3);
		check(outWord(0, 1, 24), 32'h00452310);
		check(recWords[0], 32'h00debca0);
		// AC-link 1.0 with one command
		for (int i = 0; i < 256; i += 32) putIn(0, i, 32, 32'h0);
		regWr(cpt_pkg::ADDR_CTRL, 32'h0);
		acMode <= 1'b1;
		putIn(0, 1, 16, 32'hf000);
		putIn(0, 17, 20, 32'h1a000);
		putIn(0, 37, 20, 32'h0f0f0);
		putIn(0, 57, 20, 32'habcd0);
		putIn(0, 77, 20, 32'h12340);
		playTab[3] = 32'hffff1234;
		playTab[4] = 32'h0000beef;
		regWr(cpt_pkg::ADDR_SLOTCFG, 32'h00101410);
		regWr(cpt_pkg::ADDR_TAGS, 32'h00c);
		regWr(cpt_pkg::ADDR_CMDADDR, 32'h1c000);
		regWr(cpt_pkg::ADDR_CTRL, 32'hc6);
		waitFrames(2);
		regWr(cpt_pkg::ADDR_CMDDATA, 32'h5a5a0);
		for (int f = 0; f < 4; f++) begin
			waitFrames(1);
			cmdSeen = codec_u.outBits[2];
			cmdHits += int'(cmdSeen === 1'b1);
			check(outWord(0, 1, 16), cmdSeen ? 32'hf800 : 32'h9800);
			check(outWord(0, 17, 20), cmdSeen ? 32'h1c000 : 32'h0);
			check(outWord(0, 37, 20), cmdSeen ? 32'h5a5a0 : 32'h0);
			check(outWord(0, 57, 20), 32'h12340);
			check(outWord(0, 77, 20), 32'hbeef0);
			check(outWord(0, 97, 20), 32'h0);
		end
		check(32'(cmdHits), 32'h1);
		check(outWord(0, 237, 19), 32'h0);
		check(32'(codec_u.frameCycles), 32'(256 * 2 * BIT_HALF));
		check(outWord(1, 0, 17), 32'h1fffe);
		check(32'(serialBitClockPinOe), 32'h0);
		check(32'(codecResetOutn), 32'h1);
		regRd(cpt_pkg::ADDR_STSADDR, 32'h1a000);
		regRd(cpt_pkg::ADDR_STSDATA, 32'h0f0f0);
		regRd(cpt_pkg::ADDR_STATUS, 32'h0000f000);
		check(recWords[3], 32'h0000abcd);
		check(32'(recHits[4]), 32'h0);
		mclkRises = 0;
		repeat (1000) @(negedge clock);
		check(32'(mclkRises inside {[490:493]}), 32'h1);
		// AC-link 2.0, two codecs, on-demand asked for but not allowed
		putIn(0, 1, 16, 32'hf800);
		putIn(0, 17, 20, 32'h1a400);
		putIn(0, 77, 20, 32'h0);
		putIn(1, 77, 20, 32'h5aa50);
		regWr(cpt_pkg::ADDR_CTRL, 32'hf7);
		waitFrames(3);
		playHits = '{default: 0};
		waitFrames(2);
		check(recWords[4], 32'h00005aa5);
		check(32'(playHits[4] > 0), 32'h1);
		// Single codec with on-demand sampling
		putIn(1, 77, 20, 32'h0);
		regWr(cpt_pkg::ADDR_CTRL, 32'hd7);
		waitFrames(3);
		playHits = '{default: 0};
		waitFrames(2);
		check(32'(playHits[3] > 0), 32'h1);
		check(32'(playHits[4]), 32'h0);
		regRd(cpt_pkg::ADDR_STATUS, 32'h0200f800);
		printVerdict();
	end
endmodule // codec_port_tdm_serial_bench
